// ===== bench/test_usb_device_irq_enable_set_logic.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// register-level regression of the set and enable logic
module test_usb_device_irq_enable_set_logic
    import uie_pkg::*;
;
    logic clk_sys, rstn, reg_wr, reg_rd, irq;
    logic [15:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [5:0] ev;
    logic [6:0] ep_irq;
    int n_mismatch = 0;
    int total_checks = 0;
    int g;

    uie_top dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ev_suspend(ev[0]), .ev_frame_start(ev[1]),
        .ev_bus_reset_end(ev[2]), .ev_wake(ev[3]), .ev_resume_end(ev[4]),
        .ev_upstream_resume(ev[5]), .ep_irq(ep_irq), .irq(irq));

    // ============================================================
    // clock and helpers
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task chk(input string what, input logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one bus cycle; launched just after an edge, ends just after the next
    task bus(input logic w, r, logic [15:0] a, logic [31:0] d);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        #1;
    endtask

    task wr(input logic [15:0] a, logic [31:0] d);
        bus(1'b1, 1'b0, a, d);
    endtask

    // read data stand in the cycle after the strobe, i.e. now
    task rd(input logic [15:0] a, logic [31:0] exp);
        bus(1'b0, 1'b1, a, 32'h0);
        chk("rdata", reg_rdata, exp);
    endtask

    task idle;
        bus(1'b0, 1'b0, 16'h0, 32'h0);
    endtask

    task report_and_stop;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ============================================================
    // test sequence
    initial
    begin
        rstn = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'h0;
        reg_wdata = 32'h0;
        ev = 6'h0;
        ep_irq = 7'h0;
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        #1;
        rd(OFS_ENABLE_MASK, MASK_RESET);
        chk("irq", irq, 32'h0);
        $display("test reset done");
        // all-ones set must land only on implemented bits
        wr(OFS_ENABLE_SET, 32'hffffffff);
        rd(OFS_ENABLE_MASK, ENABLE_BITS);
        rd(OFS_FORCE_SET, READ_ZERO);
        rd(OFS_ENABLE_CLEAR, READ_ZERO);
        rd(OFS_ENABLE_SET, READ_ZERO);
        rd(16'h0020, 32'h0);
        wr(OFS_ENABLE_CLEAR, 32'h0);
        rd(OFS_ENABLE_MASK, ENABLE_BITS);
        $display("test access done");
        // each enable bit alone, endpoints at 12 upward
        for (g = 0; g < 32; g++)
            if (ENABLE_BITS[g])
            begin
                wr(OFS_ENABLE_CLEAR, 32'h1 << g);
                rd(OFS_ENABLE_MASK, ENABLE_BITS & ~(32'h1 << g));
                wr(OFS_ENABLE_SET, 32'h1 << g);
                rd(OFS_ENABLE_MASK, ENABLE_BITS);
            end
        wr(OFS_ENABLE_CLEAR, ENABLE_BITS);
        $display("test enables done");
        // forced flag is blocked, then passed, then cleared
        for (g = 0; g < 7; g++)
            if (GLOBAL_BITS[g])
            begin
                wr(OFS_FORCE_SET, 32'h1 << g);
                rd(OFS_FLAGS, 32'h1 << g);
                chk("irq", irq, 32'h0);
                wr(OFS_ENABLE_SET, 32'h1 << g);
                rd(OFS_ENABLE_MASK, 32'h1 << g);
                chk("irq", irq, 32'h1);
                wr(OFS_FLAG_CLEAR, 32'h1 << g);
                rd(OFS_FLAGS, 32'h0);
                chk("irq", irq, 32'h0);
                wr(OFS_ENABLE_CLEAR, 32'h1 << g);
            end
        // wake knocks out suspend; an event beats a same-cycle clear
        wr(OFS_FORCE_SET, 32'h1);
        wr(OFS_FORCE_SET, 32'h10);
        rd(OFS_FLAGS, 32'h10);
        ev <= 6'h2;
        wr(OFS_FLAG_CLEAR, GLOBAL_BITS);
        ev <= 6'h0;
        rd(OFS_FLAGS, 32'h4);
        wr(OFS_FLAG_CLEAR, GLOBAL_BITS);
        $display("test force done");
        // back-to-back enable then force, then real events
        wr(OFS_ENABLE_SET, ENABLE_BITS);
        wr(OFS_FORCE_SET, 32'h4);
        idle();
        chk("irq", irq, 32'h1);
        wr(OFS_FLAG_CLEAR, 32'h4);
        for (g = 0; g < 6; g++)
        begin
            ev <= 6'h1 << g;
            idle();
            ev <= 6'h0;
            rd(OFS_FLAGS, 32'h1 << (g == 0 ? 0 : g + 1));
            wr(OFS_FLAG_CLEAR, GLOBAL_BITS);
        end
        // endpoint 0 and 6 levels
        ep_irq <= 7'h41;
        idle();
        rd(OFS_FLAGS, 32'h00041000);
        chk("irq", irq, 32'h1);
        wr(OFS_ENABLE_CLEAR, ENABLE_BITS);
        idle();
        chk("irq", irq, 32'h0);
        ep_irq <= 7'h0;
        $display("test events done");
        // mid-run reset must drop the mask, the flags and the interrupt
        wr(OFS_ENABLE_SET, ENABLE_BITS);
        wr(OFS_FORCE_SET, GLOBAL_BITS);
        rstn <= 1'b0;
        idle();
        rstn <= 1'b1;
        rd(OFS_ENABLE_MASK, MASK_RESET);
        rd(OFS_FLAGS, FLAGS_RESET);
        chk("irq", irq, 32'h0);
        $display("test second reset done");
        report_and_stop();
    end

    // hang guard at 5000 cycles, far beyond the fewer than 200 cycles the tests need
    initial
    begin
        #100000;
        n_mismatch++;
        report_and_stop();
    end
endmodule

`default_nettype wire

// ===== bench/uie_top_monitor.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// port-level checks of the force-set, flag-clear and enable registers and the interrupt
module uie_monitor
    import uie_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic ev_frame_start,
    input wire logic irq
);
    // single domain, so one clock and one reset serve every check
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    // decoded strobes, kept short so the properties stay readable
    logic wr_fs, wr_es, wr_ec, wr_fc, rd_fl, rd_mk, rd_wo;
    assign wr_fs = reg_wr && reg_addr == OFS_FORCE_SET;
    assign wr_es = reg_wr && reg_addr == OFS_ENABLE_SET;
    assign wr_ec = reg_wr && reg_addr == OFS_ENABLE_CLEAR;
    assign wr_fc = reg_wr && reg_addr == OFS_FLAG_CLEAR;
    assign rd_fl = reg_rd && reg_addr == OFS_FLAGS;
    assign rd_mk = reg_rd && reg_addr == OFS_ENABLE_MASK;
    assign rd_wo = reg_rd && (reg_addr == OFS_FLAG_CLEAR
        || reg_addr == OFS_FORCE_SET || reg_addr == OFS_ENABLE_CLEAR
        || reg_addr == OFS_ENABLE_SET);

    a_wo_read_zero:
        assert property (rd_wo |=> reg_rdata == 32'h0)
        else $error("write-only register read back nonzero");
    a_force_sets_flag:
        assert property (wr_fs ##1 rd_fl |=> (reg_rdata & $past(reg_wdata, 2)
            & GLOBAL_BITS) == ($past(reg_wdata, 2) & GLOBAL_BITS))
        else $error("force-set did not raise the flag");
    a_enable_set_bits:
        assert property (wr_es ##1 rd_mk |=> (reg_rdata & $past(reg_wdata, 2)
            & ENABLE_BITS) == ($past(reg_wdata, 2) & ENABLE_BITS))
        else $error("enable-set did not set the mask");
    a_enable_clr_bits:
        assert property (wr_ec ##1 rd_mk
            |=> (reg_rdata & $past(reg_wdata, 2)) == 32'h0)
        else $error("enable-clear did not clear the mask");
    a_mask_unused_zero:
        assert property (rd_mk |=> (reg_rdata & ~ENABLE_BITS) == 32'h0)
        else $error("mask shows an unused bit");
    a_irq_needs_enable:
        assert property (rd_mk ##1 reg_rdata == 32'h0 |-> !irq)
        else $error("interrupt with an empty mask");
    a_irq_follows_flag:
        assert property (wr_es && reg_wdata[2] ##1 wr_fs && reg_wdata[2]
            |-> ##2 irq)
        else $error("enabled flag gave no interrupt");
    a_irq_off_masked:
        assert property (wr_ec && reg_wdata == ENABLE_BITS |-> ##2 !irq)
        else $error("interrupt stayed after full disable");
    a_flag_clear_works:
        assert property (wr_fc && reg_wdata[2] && !ev_frame_start ##1 rd_fl
            |=> !reg_rdata[2])
        else $error("flag-clear left the flag set");
endmodule

bind uie_top uie_monitor u_mon (.clk_sys(clk_sys), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ev_frame_start(ev_frame_start), .irq(irq));

`default_nettype wire

// ===== rtl/uie_flags.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// sticky global interrupt flags
module uie_flags
    import uie_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [31:0] set_bits,
    input wire logic [31:0] clear_bits,
    output logic [31:0] flags
);

    logic [31:0] flags_r;
    logic [31:0] flags_nxt;

    // next flags: set beats clear, so no event is lost to a clear
    always_comb
    begin
        logic [31:0] set_v;
        logic [31:0] drop_v;
        set_v = set_bits & GLOBAL_BITS;
        drop_v = clear_bits & GLOBAL_BITS;
        // suspend and wake knock each other out when newly set
        if (set_v[BIT_WAKE] && !set_v[BIT_SUSPEND])
        begin
            drop_v[BIT_SUSPEND] = 1'b1;
        end
        if (set_v[BIT_SUSPEND] && !set_v[BIT_WAKE])
        begin
            drop_v[BIT_WAKE] = 1'b1;
        end
        flags_nxt = (flags_r & ~drop_v) | set_v;
    end

    // register only
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            flags_r <= FLAGS_RESET;
        end
        else
        begin
            flags_r <= flags_nxt;
        end
    end

    assign flags = flags_r;

endmodule

`default_nettype wire

// ===== rtl/uie_pkg.sv
// ============================================================
// constants shared by the interrupt set/enable logic
package uie_pkg;

    // ============================================================
    // bus geometry
    localparam int DATA_W = 32;
    localparam int ADDR_W = 16;

    // ============================================================
    // register byte offsets
    localparam logic [15:0] OFS_FLAGS = 16'h0004;
    localparam logic [15:0] OFS_FLAG_CLEAR = 16'h0008;
    localparam logic [15:0] OFS_FORCE_SET = 16'h000c;
    localparam logic [15:0] OFS_ENABLE_MASK = 16'h0010;
    localparam logic [15:0] OFS_ENABLE_CLEAR = 16'h0014;
    localparam logic [15:0] OFS_ENABLE_SET = 16'h0018;

    // ============================================================
    // field positions of the global events
    localparam int BIT_SUSPEND = 0;
    localparam int BIT_FRAME_START = 2;
    localparam int BIT_BUS_RESET_END = 3;
    localparam int BIT_WAKE = 4;
    localparam int BIT_RESUME_END = 5;
    localparam int BIT_UPSTREAM_RESUME = 6;

    // endpoint interrupts sit from this bit upward, one per endpoint
    localparam int EP_BASE = 12;
    localparam int EP_COUNT = 7;

    // ============================================================
    // field masks and reset values
    localparam logic [31:0] GLOBAL_BITS = 32'h0000007d;
    localparam logic [31:0] EP_BITS = 32'h0007f000;
    localparam logic [31:0] ENABLE_BITS = 32'h0007f07d;
    localparam logic [31:0] FLAGS_RESET = 32'h00000000;
    localparam logic [31:0] MASK_RESET = 32'h00000000;
    localparam logic [31:0] READ_ZERO = 32'h00000000;

    // ============================================================
    // read source selected by an address
    typedef enum logic [1:0] {
        RSEL_NONE,
        RSEL_FLAGS,
        RSEL_MASK,
        RSEL_WRITE_ONLY
    } uie_rsel_e;

endpackage

// ===== rtl/uie_top.sv
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module uie_top
    import uie_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic ev_suspend,
    input wire logic ev_frame_start,
    input wire logic ev_bus_reset_end,
    input wire logic ev_wake,
    input wire logic ev_resume_end,
    input wire logic ev_upstream_resume,
    input wire logic [EP_COUNT-1:0] ep_irq,
    output logic irq
);

    // ============================================================
    // helper functions
    // shared by the write decode and the read port

    // exact word match; an unaligned address hits nothing
    // byte lanes are not decoded: full 32-bit words only
    function automatic logic addr_hit(
        input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] ofs
    );
        return a == ofs;
    endfunction

    // which source answers a read at this address
    // flag-clear answers like the other write-only registers
    function automatic uie_rsel_e read_select(
        input logic [ADDR_W-1:0] a
    );
        uie_rsel_e sel;
        sel = RSEL_NONE;
        if (addr_hit(a, OFS_FLAGS))
        begin
            sel = RSEL_FLAGS;
        end
        else if (addr_hit(a, OFS_ENABLE_MASK))
        begin
            sel = RSEL_MASK;
        end
        else if (addr_hit(a, OFS_FLAG_CLEAR) ||
                 addr_hit(a, OFS_FORCE_SET) ||
                 addr_hit(a, OFS_ENABLE_CLEAR) ||
                 addr_hit(a, OFS_ENABLE_SET))
        begin
            sel = RSEL_WRITE_ONLY;
        end
        return sel;
    endfunction

    // write data as a bit action, gated by strobe and address
    // the field mask keeps reserved bits out of every register
    function automatic logic [31:0] write_bits(
        input logic wr,
        input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] ofs,
        input logic [31:0] wdata,
        input logic [31:0] field
    );
        logic [31:0] bits;
        bits = READ_ZERO;
        if (wr && addr_hit(a, ofs))
        begin
            bits = wdata & field;
        end
        return bits;
    endfunction

    // ============================================================
    // declarations

    // one-bit actions decoded from the write registers
    logic [31:0] flag_clr_bits;
    logic [31:0] force_set_bits;
    logic [31:0] en_clr_bits;
    logic [31:0] en_set_bits;

    // flag sources and the flags as software reads them
    logic [31:0] event_bits;
    logic [31:0] flag_set_bits;
    logic [31:0] global_irq_flags;
    logic [31:0] flag_view;

    // endpoint level sample
    logic [EP_COUNT-1:0] ep_r;
    logic [EP_COUNT-1:0] ep_nxt;

    // enable mask state
    logic [31:0] global_irq_enable_mask_r;
    logic [31:0] global_irq_enable_mask_nxt;

    // interrupt: sources both flagged and enabled
    logic [31:0] pending;
    logic irq_r;
    logic irq_nxt;

    // read port
    uie_rsel_e rd_sel;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;

    // ============================================================
    // write decode
    // a write touches at most one register; the rest see zeros

    // flag-clear: ones drop global flags, endpoint bits have no clear
    always_comb
    begin
        flag_clr_bits = write_bits(reg_wr, reg_addr, OFS_FLAG_CLEAR,
                                   reg_wdata, GLOBAL_BITS);
    end

    // force-set: test hook, raises flags without the bus event
    always_comb
    begin
        force_set_bits = write_bits(reg_wr, reg_addr, OFS_FORCE_SET,
                                    reg_wdata, GLOBAL_BITS);
    end

    // enable-clear: same layout as the mask, endpoint n at 12+n
    always_comb
    begin
        en_clr_bits = write_bits(reg_wr, reg_addr, OFS_ENABLE_CLEAR,
                                 reg_wdata, ENABLE_BITS);
    end

    // enable-set: same layout; a zero bit leaves the mask alone
    always_comb
    begin
        en_set_bits = write_bits(reg_wr, reg_addr, OFS_ENABLE_SET,
                                 reg_wdata, ENABLE_BITS);
    end

    // ============================================================
    // global event collection

    // hardware event pulses placed at their flag positions
    // pulses come from logic on this clock, so no synchroniser
    always_comb
    begin
        event_bits = READ_ZERO;
        event_bits[BIT_SUSPEND] = ev_suspend;
        event_bits[BIT_FRAME_START] = ev_frame_start;
        event_bits[BIT_BUS_RESET_END] = ev_bus_reset_end;
        event_bits[BIT_WAKE] = ev_wake;
        event_bits[BIT_RESUME_END] = ev_resume_end;
        event_bits[BIT_UPSTREAM_RESUME] = ev_upstream_resume;
    end

    // software force-set merges with real events; zeros add nothing
    // a force and a real event in one cycle simply both set
    always_comb
    begin
        flag_set_bits = event_bits | force_set_bits;
    end

    // ============================================================
    // sticky global flags

    // set and clear meet in one place, so set-wins is decided once
    uie_flags u_flags (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .set_bits(flag_set_bits),
        .clear_bits(flag_clr_bits),
        .flags(global_irq_flags)
    );

    // ============================================================
    // endpoint interrupt levels

    // levels from endpoint logic on this clock; sampled once
    // not sticky: a serviced endpoint drops out one cycle later
    always_comb
    begin
        ep_nxt = ep_irq;
    end

    // register only
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            ep_r <= '0;
        end
        else
        begin
            ep_r <= ep_nxt;
        end
    end

    // flags as software sees them: globals plus endpoint levels
    // endpoint bits bypass force-set and flag-clear entirely
    always_comb
    begin
        flag_view = global_irq_flags & GLOBAL_BITS;
        for (int i = 0; i < EP_COUNT; i++)
        begin
            flag_view[EP_BASE + i] = ep_r[i];
        end
    end

    // ============================================================
    // enable mask
    // reserved bits are forced to zero after every update

    // clear first then set, so a same-cycle set ends enabled
    // only reachable in theory: the bus carries one strobe a cycle
    always_comb
    begin
        global_irq_enable_mask_nxt =
            (global_irq_enable_mask_r & ~en_clr_bits)
            | en_set_bits;
        global_irq_enable_mask_nxt =
            global_irq_enable_mask_nxt & ENABLE_BITS;
    end

    // only the clear/set registers reach the mask; it has no write port
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            global_irq_enable_mask_r <= MASK_RESET;
        end
        else
        begin
            global_irq_enable_mask_r <= global_irq_enable_mask_nxt;
        end
    end

    // ============================================================
    // pending sources

    // a source is pending when its flag and its enable are both one
    // kept as a vector so a debugger sees which source fired
    always_comb
    begin
        pending = flag_view & global_irq_enable_mask_r;
    end

    // ============================================================
    // interrupt output

    // registered so the pin is glitch free; costs one cycle of latency
    always_comb
    begin
        irq_nxt = |pending;
    end

    // level interrupt register
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            irq_r <= 1'b0;
        end
        else
        begin
            irq_r <= irq_nxt;
        end
    end

    // straight from the flop, nothing after it
    assign irq = irq_r;

    // ============================================================
    // read port
    // no wait states: every read answers in the next cycle

    // address decode of a read, apart from the data mux
    always_comb
    begin
        rd_sel = read_select(reg_addr);
    end

    // data stand only in the cycle after the strobe, zero otherwise
    // a read has no side effect, so polling the flags is safe
    always_comb
    begin
        rdata_nxt = READ_ZERO;
        if (reg_rd)
        begin
            case (rd_sel)
                RSEL_FLAGS:
                begin
                    rdata_nxt = flag_view;
                end
                RSEL_MASK:
                begin
                    rdata_nxt = global_irq_enable_mask_r;
                end
                RSEL_WRITE_ONLY:
                begin
                    rdata_nxt = READ_ZERO;
                end
                default:
                begin
                    rdata_nxt = READ_ZERO; // unmapped reads as zero
                end
            endcase
        end
    end

    // read data register
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            rdata_r <= READ_ZERO;
        end
        else
        begin
            rdata_r <= rdata_nxt;
        end
    end

    // straight from the flop, zero between reads
    assign reg_rdata = rdata_r;

endmodule

`default_nettype wire
